// [logic/tgd_pkg.sv]
// constants and carriers for the three-phase gate dead-time controller
`default_nettype none
package tgd_pkg;
    // register byte offsets
    localparam logic [7:0] TGD_CTRL  = 8'h00;
    localparam logic [7:0] TGD_DEAD  = 8'h04;
    localparam logic [7:0] TGD_CAL   = 8'h08;
    localparam logic [7:0] TGD_SIMUL = 8'h0c;
    localparam logic [7:0] TGD_STAT  = 8'h10;
    localparam logic [7:0] TGD_MASK  = 8'h14;
    localparam logic [7:0] TGD_GATE  = 8'h18;
    // control field positions
    localparam int CTRL_EN    = 0;
    localparam int CTRL_FULL  = 1;
    localparam int CTRL_DESAT = 2;
    localparam int CTRL_ZDT   = 3;
    localparam int CTRL_LOCK  = 4;
    // status field positions
    localparam int ST_OC    = 0;
    localparam int ST_DESAT = 1;
    localparam int ST_OT    = 2;
    localparam int ST_ILIM  = 3;
    // reset values and keys
    localparam logic [7:0] DEAD_RST  = 8'h10;
    localparam logic [3:0] CAL_RST   = 4'h0;
    localparam logic [7:0] MASK_RST  = 8'h00;
    localparam logic [6:0] SIMUL_KEY = 7'h5a;
    localparam logic [7:0] DEAD_MAX  = 8'hff;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TB_STEP_NS    = 50;
    localparam int TB_DIV        = (TB_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_NS      = 500;
    localparam int BLANK_CYC     = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ILIM_BLANK_NS = 300;
    localparam int ILIM_CYC      = (ILIM_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OT_FILT_NS    = 1000;
    localparam int OT_FILT_CYC   = (OT_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPI_BITS      = 16;
    // carriers
    typedef struct packed {
        logic lock;
        logic zdt;
        logic desat;
        logic full;
        logic en;
    } tgd_mode_t;
    typedef struct packed {
        logic [2:0] hs;
        logic [2:0] ls;
    } tgd_gate_t;
endpackage
`default_nettype wire

// [logic/tgd_gate_ctrl.sv]
// gate dead-time controller with axi4-lite registers and serial command port
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - dead time programmable in 50 ns steps from zero to about 12.75 us
// - dead-time command sets 1 to 255 time-base cycles, larger values clamp to 255
// - a separate mode bit selects zero dead time
// - calibration register trims the time-base step; device applies it
// - leading input edge turns complementary gate off now, selected on after dead time
// - gate turning off starts phase timer, blocking complementary turn-on until expiry
// - turn-on after timer expiry happens without added delay
// - any gate turn-on starts one blanking interval for all phases
// - simultaneous drive disables blanking
// - simultaneous drive setting accepted only once after reset
// - full-on, desaturation and zero dead-time modes settable then lockable
// - per-fault report enable and interrupt mask are programmable
// - status registers readable over the serial port
// - logic synchronous to aclk, inputs pass two-flop synchronisers
// - normal path has decision stage plus full-on mux stage
// - full-on mode bypasses decision stage, one cycle shorter
// - overtemperature input filtered before it flags
// - gate stays off as long as commanded off
// - current-limit detection blanked after each input change
// - serial input sampled at falling sclk, output updated after rising sclk
// - serial output driven only while chip select is low
// - high side refused after enable until low side switched on once
// - interrupt held until fault gone and status cleared
module tgd_gate_ctrl
    import tgd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire  logic              aclk,
    input  wire  logic              aresetn,
    // axi4-lite slave
    input  wire  logic [ADDR_W-1:0] s_awaddr,
    input  wire  logic              s_awvalid,
    output logic                    s_awready,
    input  wire  logic [31:0]       s_wdata,
    input  wire  logic [3:0]        s_wstrb,
    input  wire  logic              s_wvalid,
    output logic                    s_wready,
    output logic [1:0]              s_bresp,
    output logic                    s_bvalid,
    input  wire  logic              s_bready,
    input  wire  logic [ADDR_W-1:0] s_araddr,
    input  wire  logic              s_arvalid,
    output logic                    s_arready,
    output logic [31:0]             s_rdata,
    output logic [1:0]              s_rresp,
    output logic                    s_rvalid,
    input  wire  logic              s_rready,
    // phase commands and fault comparators
    input  wire  logic [2:0]        phase_upper_gate_input,
    input  wire  logic [2:0]        phase_lower_gate_input,
    input  wire  logic              oc_in,
    input  wire  logic              ilim_in,
    input  wire  logic              desat_in,
    input  wire  logic              ot_in,
    // serial port
    input  wire  logic              spi_sclk,
    input  wire  logic              spi_cs_n,
    input  wire  logic              spi_si,
    output logic                    spi_so,
    output logic                    spi_so_oe,
    // gate drives and interrupt
    output tgd_gate_t               gate_q,
    output logic                    int_q
);
    function automatic logic [7:0] clamp_dt(input logic [31:0] v);
        if (v == 32'h0)
            clamp_dt = 8'h01;
        else if (v > {24'h0, DEAD_MAX})
            clamp_dt = DEAD_MAX;
        else
            clamp_dt = v[7:0];
    endfunction

    function automatic logic [31:0] strb_mask(input logic [31:0] d, input logic [3:0] s);
        strb_mask = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // input synchronisers
    logic [12:0] sy1_q, sy2_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sy1_q <= 13'h002;
            sy2_q <= 13'h002;
        end else begin
            sy1_q <= {phase_upper_gate_input, phase_lower_gate_input, oc_in, ilim_in,
                      desat_in, ot_in, spi_sclk, spi_cs_n, spi_si};
            sy2_q <= sy1_q;
        end
    end
    logic [2:0] hs_s, ls_s;
    logic       oc_s, ilim_s, desat_s, ot_s, sclk_s, csn_s, si_s;
    assign {hs_s, ls_s, oc_s, ilim_s, desat_s, ot_s, sclk_s, csn_s, si_s} = sy2_q;

    // register state
    tgd_mode_t  mode_q;
    logic [7:0] dead_q, mask_q;
    logic [3:0] cal_q, status_q;
    logic       sim_en_q, sim_done_q;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] clr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q     <= '0;
            dead_q     <= DEAD_RST;
            cal_q      <= CAL_RST;
            mask_q     <= MASK_RST;
            sim_en_q   <= 1'b0;
            sim_done_q <= 1'b0;
        end else if (wr_en) begin
            case (wr_addr)
                TGD_CTRL: begin
                    mode_q.en <= wr_data[CTRL_EN];
                    if (!mode_q.lock) begin
                        mode_q.full  <= wr_data[CTRL_FULL];
                        mode_q.desat <= wr_data[CTRL_DESAT];
                        mode_q.zdt   <= wr_data[CTRL_ZDT];
                        mode_q.lock  <= wr_data[CTRL_LOCK];
                    end
                end
                TGD_DEAD: dead_q <= clamp_dt(wr_data);
                TGD_CAL:  cal_q  <= wr_data[3:0];
                TGD_MASK: mask_q <= wr_data[7:0];
                TGD_SIMUL: begin
                    if (!sim_done_q && wr_data[7:1] == SIMUL_KEY) begin
                        sim_en_q   <= wr_data[0];
                        sim_done_q <= 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end
    assign clr = (wr_en && wr_addr == TGD_STAT) ? wr_data[3:0] : 4'h0;

    // time base with calibration trim; step is TB_DIV cycles nominal
    logic [4:0] tb_div, tb_cnt_q;
    logic       tb_tick;
    always_comb begin
        tb_div = 5'(TB_DIV) + {cal_q[3], cal_q};
        if (tb_div[4] || tb_div == 5'h0)
            tb_div = 5'h01;
    end
    assign tb_tick = (tb_cnt_q >= tb_div - 5'h01);
    always_ff @(posedge aclk) begin
        if (!aresetn || tb_tick)
            tb_cnt_q <= 5'h0;
        else
            tb_cnt_q <= tb_cnt_q + 5'h01;
    end

    // decision stage
    logic [2:0] hs_p_q, ls_p_q, want_hs_q, want_ls_q, want_hs, want_ls;
    logic [2:0] dec_hs_q, dec_ls_q, dec_hs, dec_ls, off_hs_q, ls_seen_q;
    logic [7:0] dt_q [3];
    logic       fault_off_q;
    logic [7:0] dt_load;
    assign dt_load = mode_q.zdt ? 8'h00 : dead_q;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            want_hs[i] = want_hs_q[i];
            want_ls[i] = want_ls_q[i];
            if (hs_s[i] && !hs_p_q[i]) begin
                want_hs[i] = 1'b1;
                want_ls[i] = 1'b0;
            end else if (ls_s[i] && !ls_p_q[i]) begin
                want_ls[i] = 1'b1;
                want_hs[i] = 1'b0;
            end
            if (!hs_s[i])
                want_hs[i] = 1'b0;
            if (!ls_s[i])
                want_ls[i] = 1'b0;
            if (sim_en_q) begin
                dec_hs[i] = hs_s[i] && ls_seen_q[i];
                dec_ls[i] = ls_s[i];
            end else begin
                // a running timer only blocks the side opposite the one that turned off
                dec_hs[i] = want_hs[i] && !dec_ls_q[i] && ls_seen_q[i]
                            && (dt_q[i] == 8'h0 || off_hs_q[i]);
                dec_ls[i] = want_ls[i] && !dec_hs_q[i]
                            && (dt_q[i] == 8'h0 || !off_hs_q[i]);
            end
            if (!mode_q.en || fault_off_q) begin
                dec_hs[i] = 1'b0;
                dec_ls[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        for (int i = 0; i < 3; i++) begin
            if (!aresetn) begin
                hs_p_q[i]    <= 1'b0;
                ls_p_q[i]    <= 1'b0;
                want_hs_q[i] <= 1'b0;
                want_ls_q[i] <= 1'b0;
                dec_hs_q[i]  <= 1'b0;
                dec_ls_q[i]  <= 1'b0;
                off_hs_q[i]  <= 1'b0;
                dt_q[i]      <= 8'h0;
            end else begin
                hs_p_q[i]    <= hs_s[i];
                ls_p_q[i]    <= ls_s[i];
                want_hs_q[i] <= want_hs[i];
                want_ls_q[i] <= want_ls[i];
                dec_hs_q[i]  <= dec_hs[i];
                dec_ls_q[i]  <= dec_ls[i];
                if (dec_hs_q[i] && !dec_hs[i]) begin
                    dt_q[i]     <= dt_load;
                    off_hs_q[i] <= 1'b1;
                end else if (dec_ls_q[i] && !dec_ls[i]) begin
                    dt_q[i]     <= dt_load;
                    off_hs_q[i] <= 1'b0;
                end else if (tb_tick && dt_q[i] != 8'h0) begin
                    dt_q[i] <= dt_q[i] - 8'h01;
                end
            end
        end
    end

    // full-on mux stage
    tgd_gate_t gate_d;
    always_comb begin
        gate_d.hs = mode_q.full ? (hs_s & ~ls_s & ls_seen_q) : dec_hs_q;
        gate_d.ls = mode_q.full ? (ls_s & ~hs_s) : dec_ls_q;
        if (!mode_q.en || fault_off_q)
            gate_d = '0;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn)
            gate_q <= '0;
        else
            gate_q <= gate_d;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !mode_q.en)
            ls_seen_q <= 3'h0;
        else
            ls_seen_q <= ls_seen_q | gate_q.ls;
    end

    // blanking, filters and fault status
    logic [7:0] blank_q, ilim_blank_q, ot_cnt_q;
    logic       blank, ot_flt;
    logic [3:0] raw, ev;
    assign blank  = (blank_q != 8'h0) && !sim_en_q;
    assign ot_flt = (ot_cnt_q == 8'(OT_FILT_CYC));
    assign raw    = {ilim_s, ot_flt, desat_s, oc_s};
    assign ev     = {ilim_s && !blank && ilim_blank_q == 8'h0, ot_flt,
                     desat_s && !blank, oc_s && !blank} & mask_q[7:4];
    always_ff @(posedge aclk) begin
        if (!aresetn)
            blank_q <= 8'h0;
        else if (|(gate_d & ~gate_q))
            blank_q <= 8'(BLANK_CYC);
        else if (blank_q != 8'h0)
            blank_q <= blank_q - 8'h01;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn)
            ilim_blank_q <= 8'h0;
        else if (hs_s != hs_p_q || ls_s != ls_p_q)
            ilim_blank_q <= 8'(ILIM_CYC);
        else if (ilim_blank_q != 8'h0)
            ilim_blank_q <= ilim_blank_q - 8'h01;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !ot_s)
            ot_cnt_q <= 8'h0;
        else if (!ot_flt)
            ot_cnt_q <= ot_cnt_q + 8'h01;
    end
    always_ff @(posedge aclk) begin
        for (int b = 0; b < 4; b++) begin
            if (!aresetn)
                status_q[b] <= 1'b0;
            else if (ev[b])
                status_q[b] <= 1'b1;
            else if (clr[b] && !raw[b])
                status_q[b] <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_q       <= 1'b0;
            fault_off_q <= 1'b0;
        end else begin
            int_q       <= |(status_q & mask_q[3:0]);
            fault_off_q <= mode_q.desat && status_q[ST_DESAT];
        end
    end

    // read mux for the bus only; serial port shifts out its own status word
    logic [31:0] rd_word;
    logic        rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (s_araddr)
            TGD_CTRL:  rd_word = {27'h0, mode_q};
            TGD_DEAD:  rd_word = {24'h0, dead_q};
            TGD_CAL:   rd_word = {28'h0, cal_q};
            TGD_SIMUL: rd_word = {30'h0, sim_done_q, sim_en_q};
            TGD_STAT:  rd_word = {28'h0, status_q};
            TGD_MASK:  rd_word = {24'h0, mask_q};
            TGD_GATE:  rd_word = {19'h0, fault_off_q, blank, ls_seen_q, 2'h0, gate_q};
            default: begin
                rd_word = 32'h0;
                rd_ok   = 1'b0;
            end
        endcase
    end

    // axi4-lite slave, one write and one read at a time
    logic [7:0]  aw_q;
    logic [31:0] wd_q;
    logic        aw_hold_q, w_hold_q, axi_wr, spi_wr_q;
    logic [7:0]  spi_addr_q, spi_data_q;
    assign axi_wr = aw_hold_q && w_hold_q && !s_bvalid;
    always_comb begin
        wr_en   = axi_wr || spi_wr_q;
        wr_addr = axi_wr ? aw_q : spi_addr_q;
        wr_data = axi_wr ? wd_q : {24'h0, spi_data_q};
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= 2'b00;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_q      <= 8'h0;
            wd_q      <= 32'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_q      <= 8'(s_awaddr);
                aw_hold_q <= 1'b1;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                wd_q     <= strb_mask(s_wdata, s_wstrb);
                w_hold_q <= 1'b1;
                s_wready <= 1'b0;
            end
            if (axi_wr) begin
                s_bvalid  <= 1'b1;
                s_bresp   <= (aw_q <= TGD_GATE && aw_q[1:0] == 2'b00) ? 2'b00 : 2'b10;
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0;
            s_rresp   <= 2'b00;
        end else if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_word;
            s_rresp   <= rd_ok ? 2'b00 : 2'b10;
        end else if (s_rvalid && s_rready) begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
        end
    end

    // serial port: 16-bit frame {wr, index[6:0], data[7:0]}, status shifted out
    logic [15:0] sh_in_q, sh_out_q;
    logic [4:0]  bit_cnt_q;
    logic        sclk_p_q, csn_p_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_p_q   <= 1'b0;
            csn_p_q    <= 1'b1;
            sh_in_q    <= 16'h0;
            sh_out_q   <= 16'h0;
            bit_cnt_q  <= 5'h0;
            spi_so     <= 1'b0;
            spi_so_oe  <= 1'b0;
            spi_wr_q   <= 1'b0;
            spi_addr_q <= 8'h0;
            spi_data_q <= 8'h0;
        end else begin
            sclk_p_q  <= sclk_s;
            csn_p_q   <= csn_s;
            spi_so_oe <= !csn_s;
            if (spi_wr_q && !axi_wr)
                spi_wr_q <= 1'b0; // a bus write in the same cycle defers it
            if (csn_p_q && !csn_s) begin
                sh_out_q  <= {fault_off_q, blank, gate_q, 4'h0, status_q};
                spi_so    <= fault_off_q;
                bit_cnt_q <= 5'h0;
            end else if (!csn_s && sclk_p_q && !sclk_s) begin
                sh_in_q   <= {sh_in_q[14:0], si_s};
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end else if (!csn_s && !sclk_p_q && sclk_s) begin
                spi_so   <= sh_out_q[15];
                sh_out_q <= {sh_out_q[14:0], 1'b0};
            end else if (!csn_p_q && csn_s && bit_cnt_q == 5'(SPI_BITS) && sh_in_q[15]) begin
                spi_wr_q   <= 1'b1;
                spi_addr_q <= {sh_in_q[13:8], 2'b00};
                spi_data_q <= sh_in_q[7:0];
            end
        end
    end
endmodule
`default_nettype wire

// [verification/tgd_gate_ctrl_asserts.sv]
// port checker for the gate dead-time controller
`timescale 1ns/1ps
`default_nettype none
module tgd_chk
    import tgd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // register bus
    input wire logic              s_awvalid,
    input wire logic              s_awready,
    input wire logic              s_wvalid,
    input wire logic              s_wready,
    input wire logic              s_bvalid,
    input wire logic              s_bready,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic              s_arvalid,
    input wire logic              s_arready,
    input wire logic [31:0]       s_rdata,
    input wire logic [1:0]        s_rresp,
    input wire logic              s_rvalid,
    input wire logic              s_rready,
    // serial, gates, interrupt
    input wire logic              spi_cs_n,
    input wire logic              spi_so_oe,
    input wire tgd_gate_t         gate_q,
    input wire logic              int_q
);
    logic [2:0] ls_seen_q;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // weaker than the device: not cleared when enable drops
    always_ff @(posedge aclk) begin
        if (!aresetn) ls_seen_q <= 3'h0;
        else ls_seen_q <= ls_seen_q | gate_q.ls;
    end
    rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=> gate_q == 6'h0 && !int_q)
        else $error("outputs active in reset");
    no_overlap_a: assert property ((gate_q.hs & gate_q.ls) == 3'h0)
        else $error("both gates of a phase on");
    upper_first_a: assert property ((gate_q.hs & ~ls_seen_q) == 3'h0)
        else $error("upper gate before lower gate");
    so_release_a: assert property (spi_cs_n [*4] |-> !spi_so_oe)
        else $error("serial out driven while deselected");
    so_drive_a: assert property (!spi_cs_n [*4] |-> spi_so_oe)
        else $error("serial out not driven while selected");
    bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("write response dropped");
    rdata_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data not held");
    wr_answer_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready
        |-> ##[1:2] s_bvalid)
        else $error("write not answered");
    rd_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read not answered");
    bad_read_a: assert property (s_arvalid && s_arready && s_araddr > 8'h18
        |=> s_rresp == 2'b10 && s_rdata == 32'h0)
        else $error("unmapped read accepted");
    cover property (s_bvalid && s_bready);
    cover property (gate_q.hs[0]);
    cover property (int_q);
endmodule
bind tgd_gate_ctrl tgd_chk #(.ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire

// [verification/tgd_spi_host.sv]
// host model for the serial command port
`timescale 1ns/1ps
`default_nettype none
module tgd_spi_host (
    // clock
    input wire logic aclk,
    // serial lines
    output logic     spi_sclk,
    output logic     spi_cs_n,
    output logic     spi_si,
    input wire logic spi_so,
    input wire logic spi_so_oe
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end
    // sclk runs only inside a frame, 160 ns period
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        spi_cs_n <= 1'b0;
        repeat (20) @(posedge aclk);
        for (int i = 15; i >= 0; i--) begin
            spi_si <= tx[i];
            spi_sclk <= 1'b1;
            repeat (8) @(posedge aclk);
            // undriven line reads as the inverse, never a lucky match
            rx[i] = spi_so_oe ? spi_so : ~spi_so;
            spi_sclk <= 1'b0;
            repeat (8) @(posedge aclk);
        end
        spi_cs_n <= 1'b1;
        spi_si <= ~spi_si;
        repeat (20) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// [verification/three_phase_gate_deadtime_control_bench.sv]
// self-checking bench for the gate dead-time controller
`timescale 1ns/1ps
`default_nettype none
module three_phase_gate_deadtime_control_bench
    import tgd_pkg::*;
;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_awaddr = 8'h0;
    logic [7:0]  s_araddr = 8'h0;
    logic [31:0] s_wdata = 32'h0;
    logic [3:0]  s_wstrb = 4'hf;
    logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic        s_arvalid = 1'b0, s_rready = 1'b0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]  s_bresp, s_rresp;
    logic [31:0] s_rdata;
    logic [2:0]  phase_upper_gate_input = 3'h0;
    logic [2:0]  phase_lower_gate_input = 3'h0;
    logic        oc_in = 1'b0, ilim_in = 1'b0, desat_in = 1'b0, ot_in = 1'b0;
    wire         spi_sclk, spi_cs_n, spi_si;
    logic        spi_so, spi_so_oe, int_q;
    tgd_gate_t   gate_q;
    int          failures = 0;
    int          n_checks = 0;
    tgd_gate_ctrl dut_u (.*);
    tgd_spi_host host_u (.*);
    always #5 aclk = ~aclk;
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic fail(input string m);
        failures++;
        $display("Error %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e) fail(m);
    endtask
    task automatic chk_rng(input int g, input int lo, input int hi, input string m);
        n_checks++;
        if (g < lo || g > hi) fail(m);
    endtask
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 3000) begin
            fail("wait timed out");
            print_verdict();
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            tick(n);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        r = s_bresp;
        s_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            tick(n);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        logic [31:0] g;
        logic [1:0]  r;
        axi_wr(a, d, r);
        axi_rd(a, g, r);
        chk(g, e, "register readback");
    endtask
    task automatic wait_gate(input int b, input logic v, output int n);
        n = 0;
        do tick(n);
        while (gate_q[b] !== v);
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] exp_dead(input logic [31:0] v);
        return (v == 32'h0) ? 32'h1 : (v > 32'hff) ? 32'hff : v;
    endfunction
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] rx;
        logic [7:0]  s;
        int          n;
        s = 8'h5a;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(TGD_DEAD, d, r);
        chk(d, DEAD_RST, "dead reset");
        axi_rd(TGD_MASK, d, r);
        chk(d, MASK_RST, "mask reset");
        axi_rd(8'h40, d, r);
        chk(r, 2'b10, "unmapped read");
        axi_wr(8'h40, 32'h0, r);
        chk(r, 2'b10, "unmapped write");
        wr_rd(TGD_DEAD, 32'h1ff, exp_dead(32'h1ff));
        wr_rd(TGD_DEAD, 32'h0, exp_dead(32'h0));
        wr_rd(TGD_CAL, 32'h3, 32'h3);
        wr_rd(TGD_CAL, 32'h0, 32'h0);
        wr_rd(TGD_SIMUL, {SIMUL_KEY, 1'b0}, 32'h2);
        wr_rd(TGD_SIMUL, {SIMUL_KEY, 1'b1}, 32'h2);
        wr_rd(TGD_CTRL, 32'h08, 32'h08);
        wr_rd(TGD_CTRL, 32'h11, 32'h11);
        wr_rd(TGD_CTRL, 32'h1b, 32'h11);
        host_u.frame({1'b1, 7'h01, 8'h04}, rx);
        axi_rd(TGD_DEAD, d, r);
        chk(d, exp_dead(32'h4), "serial dead write");
        $display("test registers done");
        axi_wr(TGD_MASK, 32'h11, r);
        oc_in <= 1'b1;
        repeat (20) @(posedge aclk);
        axi_rd(TGD_STAT, d, r);
        chk(d, 32'h1, "status oc");
        host_u.frame({1'b0, 7'h04, 8'h00}, rx);
        chk(rx[9:0], 10'h001, "serial status");
        chk(int_q, 1'b1, "int raised");
        axi_wr(TGD_STAT, 32'h1, r);
        repeat (4) @(posedge aclk);
        chk(int_q, 1'b1, "int held");
        oc_in <= 1'b0;
        repeat (20) @(posedge aclk);
        axi_wr(TGD_STAT, 32'h1, r);
        repeat (4) @(posedge aclk);
        chk(int_q, 1'b0, "int cleared");
        $display("test faults done");
        phase_upper_gate_input <= 3'h1;
        repeat (60) @(posedge aclk);
        chk(gate_q.hs, 3'h0, "upper before lower");
        phase_upper_gate_input <= 3'h0;
        phase_lower_gate_input <= 3'h1;
        wait_gate(0, 1'b1, n);
        repeat (40) @(posedge aclk);
        phase_lower_gate_input <= 3'h0;
        phase_upper_gate_input <= 3'h1;
        wait_gate(0, 1'b0, n);
        wait_gate(3, 1'b1, n);
        chk_rng(n, 3 * TB_DIV, 4 * TB_DIV + 2, "dead time");
        phase_upper_gate_input <= 3'h0;
        wait_gate(3, 1'b0, n);
        repeat (40) @(posedge aclk);
        phase_lower_gate_input <= 3'h1;
        wait_gate(0, 1'b1, n);
        chk_rng(n, 2, 6, "late turn-on");
        axi_rd(TGD_GATE, d, r);
        chk(d, 32'h901, "gate word");
        $display("test dead time done");
        for (int i = 0; i < 150; i++) begin
            s = lfsr(s);
            phase_upper_gate_input <= s[2:0];
            phase_lower_gate_input <= s[5:3];
            repeat (7) @(posedge aclk);
        end
        phase_upper_gate_input <= 3'h0;
        phase_lower_gate_input <= 3'h0;
        repeat (60) @(posedge aclk);
        chk(gate_q, 6'h0, "gates held off");
        $display("test random done");
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_wr(TGD_CTRL, 32'h3, r);
        phase_lower_gate_input <= 3'h2;
        wait_gate(1, 1'b1, n);
        chk_rng(n, 2, 4, "full-on");
        $display("test full-on done");
        print_verdict();
    end
endmodule
`default_nettype wire
